// File: logic/smrac_map.svh
// offsets, field positions, reset values and address windows of the region controller
`ifndef SMRAC_MAP_SVH
`define SMRAC_MAP_SVH
`define SMRAC_OFF_CTRL      8'h60
`define SMRAC_OFF_EXT       8'h61
`define SMRAC_CTRL_RESET    8'h02
`define SMRAC_EXT_RESET     8'h38
`define SMRAC_BIT_OPEN      6
`define SMRAC_BIT_CLOSE     5
`define SMRAC_BIT_LOCK      4
`define SMRAC_BIT_GEN       3
`define SMRAC_BASE_SEG      3'h2
`define SMRAC_BIT_HEN       7
`define SMRAC_BIT_ERR       6
`define SMRAC_EXT_FIXED     8'h38
`define SMRAC_BIT_TEN       0
`define SMRAC_CSEG_LO       32'h000A_0000
`define SMRAC_CSEG_HI       32'h000B_FFFF
`define SMRAC_HSEG_LO       32'hFEDA_0000
`define SMRAC_HSEG_HI       32'hFEDB_FFFF
`define SMRAC_TSEG_SIZE     32'h0010_0000
`endif

// File: logic/smrac_pkg.sv
// types shared by the management-memory access controller
`default_nettype none
package smrac_pkg;
  // one processor or hub access presented for decode
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        smm;
    logic        code;
    logic        from_hub;
  } smrac_req_t;
  // routing decision for that access
  typedef struct packed {
    logic        valid;
    logic        to_dram;
    logic        to_hub;
    logic        refused;
    logic [31:0] dram_addr;
  } smrac_resp_t;
endpackage
`default_nettype wire

// File: logic/smrac_top.sv
// management-memory access controller: control registers and access routing
//
// Functional notes
// R1 - open, close, lock work only when enabled
// R2 - software clears open before setting lock
// R3 - open and unlocked exposes region outside management mode
// R4 - software never sets open and close together
// R5 - close blocks data, keeps code references
// R6 - close covers low, high and top regions
// R7 - lock clears open, freezes listed fields
// R8 - lock set by write, cleared by reset
// R9 - global enable provides low region at A0000h
// R10 - high and top regions need global enable
// R11 - base segment field reads fixed 010
// R12 - no remap; otherwise forward to hub
// R13 - high alias redirects to A0000h-BFFFFh
// R14 - outside-mode extended access sets error, write-one clears
// R15 - cacheable and cache-level bits read one
// R16 - top enable maps 1 Mbyte top segment
// R17 - hub-initiated access never reaches low region
// R18 - reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "smrac_map.svh"
module smrac_top #(
  parameter logic [31:0] TSEG_BASE = 32'h0FF0_0000 // top segment start, 1 Mbyte aligned
) (
  input  wire logic                  clk_sys,     // 20 MHz core clock
  input  wire logic                  resetn,      // synchronous reset, active low
  input  wire logic                  cfg_wr,      // configuration byte write strobe
  input  wire logic                  cfg_rd,      // configuration byte read strobe
  input  wire logic [7:0]            cfg_addr,    // configuration byte offset
  input  wire logic [7:0]            cfg_wdata,   // write data
  output logic [7:0]                 cfg_rdata,   // read data, one cycle after strobe
  output logic                       cfg_rvalid,  // read data valid pulse
  output logic                       cfg_locked,  // frozen state for other config fields
  input  wire smrac_pkg::smrac_req_t req,         // access to decode
  output smrac_pkg::smrac_resp_t     resp         // routing decision, one cycle later
);
  import smrac_pkg::*;

  // refuse a top segment base that the range decode cannot serve
  if (TSEG_BASE[19:0] != 20'h0_0000)
  begin : g_tseg_align
    $error("top segment base must be 1 Mbyte aligned");
  end

  // ----------------------------------------------------------------
  // control register state
  // ----------------------------------------------------------------
  logic open_q, open_d, close_q, close_d, lock_q, lock_d, gen_q, gen_d;
  logic hen_q, hen_d, ten_q, ten_d, err_q, err_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic err_set;

  // next values of the control bits
  always_comb
  begin
    open_d  = open_q;
    close_d = close_q;
    lock_d  = lock_q;
    gen_d   = gen_q;
    hen_d   = hen_q;
    ten_d   = ten_q;
    err_d   = err_q;
    if (cfg_wr && cfg_addr == `SMRAC_OFF_CTRL)
    begin
      if (!lock_q)
        gen_d = cfg_wdata[`SMRAC_BIT_GEN];                  // [R7]
      if (gen_q)                                            // [R1]
      begin
        close_d = cfg_wdata[`SMRAC_BIT_CLOSE];
        if (!lock_q)
        begin
          lock_d = cfg_wdata[`SMRAC_BIT_LOCK];              // [R8]
          open_d = cfg_wdata[`SMRAC_BIT_LOCK] ? 1'b0 : cfg_wdata[`SMRAC_BIT_OPEN]; // [R7]
        end
      end
    end
    else if (cfg_wr && cfg_addr == `SMRAC_OFF_EXT)
    begin
      if (!lock_q)
      begin
        hen_d = cfg_wdata[`SMRAC_BIT_HEN];                  // [R7]
        ten_d = cfg_wdata[`SMRAC_BIT_TEN];
      end
      if (cfg_wdata[`SMRAC_BIT_ERR])
        err_d = 1'b0;                                       // [R14]
    end
    if (err_set)
      err_d = 1'b1;                                         // [R14] set beats clear
  end

  // read mux; base segment and cache bits fixed, reserved zero
  always_comb
  begin
    rdata_d  = 8'h00;
    rvalid_d = cfg_rd;
    if (cfg_rd && cfg_addr == `SMRAC_OFF_CTRL)
    begin
      rdata_d[2:0]              = `SMRAC_BASE_SEG;          // [R11]
      rdata_d[`SMRAC_BIT_GEN]   = gen_q;
      rdata_d[`SMRAC_BIT_LOCK]  = lock_q;
      rdata_d[`SMRAC_BIT_CLOSE] = close_q;
      rdata_d[`SMRAC_BIT_OPEN]  = open_q;                   // [R18] bit 7 zero
    end
    else if (cfg_rd && cfg_addr == `SMRAC_OFF_EXT)
    begin
      rdata_d                   = `SMRAC_EXT_FIXED;         // [R15]
      rdata_d[`SMRAC_BIT_HEN]   = hen_q;
      rdata_d[`SMRAC_BIT_ERR]   = err_q;
      rdata_d[`SMRAC_BIT_TEN]   = ten_q;                    // [R18] bits 2:1 zero
    end
  end

  // register the control bits; lock drops only here
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      open_q   <= 1'b0;
      close_q  <= 1'b0;
      lock_q   <= 1'b0;                                     // [R8]
      gen_q    <= 1'b0;
      hen_q    <= 1'b0;
      ten_q    <= 1'b0;
      err_q    <= 1'b0;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      open_q   <= open_d;
      close_q  <= close_d;
      lock_q   <= lock_d;
      gen_q    <= gen_d;
      hen_q    <= hen_d;
      ten_q    <= ten_d;
      err_q    <= err_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic in_cseg, in_hseg, in_tseg, visible, hit_h, hit_t;
  smrac_resp_t resp_q, resp_d;

  // region hits and visibility of management memory
  always_comb
  begin
    in_cseg = req.addr >= `SMRAC_CSEG_LO && req.addr <= `SMRAC_CSEG_HI;
    in_hseg = req.addr >= `SMRAC_HSEG_LO && req.addr <= `SMRAC_HSEG_HI;
    in_tseg = req.addr >= TSEG_BASE && req.addr <= TSEG_BASE + (`SMRAC_TSEG_SIZE - 32'h1);
    visible = gen_q && (req.smm || (open_q && !lock_q))     // [R3] [R9]
              && !(close_q && !req.code);                   // [R5] [R6]
    hit_h   = gen_q && hen_q && in_hseg;                    // [R10] [R13]
    hit_t   = gen_q && ten_q && in_tseg;                    // [R10] [R16]
    err_set = req.valid && !req.from_hub && !req.smm && (hit_h || hit_t); // [R14]
  end

  // routing decision
  always_comb
  begin
    resp_d           = '0;
    resp_d.valid     = req.valid;
    resp_d.dram_addr = req.addr;
    if (req.valid)
    begin
      if (req.from_hub && in_cseg && gen_q)
        resp_d.refused = 1'b1;                              // [R17]
      else if (!req.from_hub && in_cseg && visible)
        resp_d.to_dram = 1'b1;                              // [R12] address kept
      else if (!req.from_hub && hit_h && visible)
      begin
        resp_d.to_dram   = 1'b1;
        resp_d.dram_addr = {12'h000, req.addr[19:0]};       // [R13]
      end
      else if (!req.from_hub && hit_t && visible)
        resp_d.to_dram = 1'b1;                              // [R16]
      else
        resp_d.to_hub = 1'b1;                               // [R12]
    end
  end

  // register the decision
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      resp_q <= '0;
    else
      resp_q <= resp_d;
  end

  assign cfg_rdata  = rdata_q;
  assign cfg_rvalid = rvalid_q;
  assign cfg_locked = lock_q;
  assign resp       = resp_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence wr_ctrl_s;
    cfg_wr && cfg_addr == `SMRAC_OFF_CTRL;
  endsequence

  disabled_ctrl_a: assert property (wr_ctrl_s ##0 !gen_q |=> $stable(open_q) && $stable(close_q) && $stable(lock_q)) else $error("control changed while disabled"); // [R1]
  open_vis_a: assert property (req.valid && !req.from_hub && !req.smm && in_cseg && gen_q && open_q && !lock_q && !close_q |=> resp.to_dram) else $error("open region not visible"); // [R3]
  close_data_a: assert property (req.valid && close_q && !req.code && !req.from_hub |=> !resp.to_dram) else $error("closed data reference reached memory"); // [R5] [R6]
  lock_open_a: assert property (wr_ctrl_s ##0 gen_q && cfg_wdata[`SMRAC_BIT_LOCK] |=> lock_q && !open_q) else $error("lock did not clear open"); // [R7]
  lock_sticky_a: assert property (lock_q |=> lock_q && $stable(gen_q) && $stable(hen_q) && $stable(ten_q)) else $error("locked field changed"); // [R7] [R8]
  base_seg_a: assert property (cfg_rd && cfg_addr == `SMRAC_OFF_CTRL |=> cfg_rvalid && cfg_rdata[2:0] == 3'h2 && !cfg_rdata[7]) else $error("base segment wrong"); // [R11] [R18]
  ext_fixed_a: assert property (cfg_rd && cfg_addr == `SMRAC_OFF_EXT |=> cfg_rdata[5:1] == 5'h1C) else $error("fixed bits wrong"); // [R15] [R18]
  high_remap_a: assert property (req.valid && req.smm && !req.from_hub && in_hseg && gen_q && hen_q && !close_q |=> resp.to_dram && resp.dram_addr[31:20] == 12'h000) else $error("high alias not remapped"); // [R13]
  err_set_a: assert property (err_set |=> err_q) else $error("error flag not set"); // [R14]
  hub_block_a: assert property (req.valid && req.from_hub && in_cseg && gen_q |=> resp.refused && !resp.to_dram) else $error("hub reached low region"); // [R17]
  ge_off_a: assert property (req.valid && !gen_q |=> !resp.to_dram) else $error("region open without enable"); // [R9] [R10]

endmodule
`default_nettype wire

// File: sim/smrac_host.sv
// host bus model issuing management and normal accesses
`timescale 1ns/1ps
`default_nettype none
module smrac_host (
  input  wire logic                  clk_sys, // core clock
  output var smrac_pkg::smrac_req_t  req      // access to the controller
);
  import smrac_pkg::*;
  initial req = '0;
  // one access held over one edge, then released with inverted fields
  task automatic issue(input logic [31:0] a, input logic s, c, h);
    @(negedge clk_sys);
    req = '{1'b1, a, s, c, h};
    @(negedge clk_sys);
    req = '{1'b0, ~a, ~s, ~c, ~h};
  endtask
endmodule
`default_nettype wire

// File: sim/smrac_top_tb.sv
// self-checking bench for the management-memory access controller
`timescale 1ns/1ps
`default_nettype none
module smrac_top_tb;
  import smrac_pkg::*;
  localparam logic [31:0] TB = 32'h0FF0_0000; // top segment base
  logic        clk_sys, resetn, cfg_wr, cfg_rd, cfg_rvalid, cfg_locked;
  logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
  smrac_req_t  req;
  smrac_resp_t resp;
  int          num_errors = 0;
  int          total_checks = 0;
  smrac_top #(.TSEG_BASE(TB)) dut (.clk_sys(clk_sys), .resetn(resetn), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .cfg_locked(cfg_locked), .req(req), .resp(resp));
  smrac_host host (.clk_sys(clk_sys), .req(req));
  // ---------------------------------------------------------------
  // clock and tasks
  // ---------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // compare one value, four-state
  task automatic chk(input string n, input logic [31:0] e, s);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys);
    cfg_addr  = a;
    cfg_wdata = d;
    cfg_wr    = 1'b1;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk_sys);
    cfg_addr = a;
    cfg_rd   = 1'b1;
    @(negedge clk_sys);
    cfg_rd = 1'b0;
    chk("cfg_rvalid", 1, cfg_rvalid);
    chk("cfg_rdata", e, cfg_rdata);
  endtask
  // one access and its routing; e of zero skips the address
  task automatic acc(input logic [31:0] a, input logic s, c, h, d, r, input logic [31:0] e);
    host.issue(a, s, c, h);
    chk("resp.valid", 1, resp.valid);
    chk("resp.to_dram", d, resp.to_dram);
    chk("resp.refused", r, resp.refused);
    chk("resp.to_hub", !d && !r, resp.to_hub);
    if (d && e != 0)
      chk("resp.dram_addr", e, resp.dram_addr);
  endtask
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    {resetn, cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = '0;
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    rd(8'h60, 8'h02);
    rd(8'h61, 8'h38);
    rd(8'h70, 8'h00);
    wr(8'h60, 8'h70);
    rd(8'h60, 8'h02);
    acc(32'h000A_1234, 1, 0, 0, 0, 0, 0);
    wr(8'h60, 8'h88);
    rd(8'h60, 8'h0A);
    wr(8'h61, 8'hC7);
    rd(8'h61, 8'hB9);
    acc(32'h000A_1234, 1, 0, 0, 1, 0, 32'h000A_1234);
    acc(32'h000A_1234, 0, 0, 0, 0, 0, 0);
    acc(32'h000A_1234, 1, 0, 1, 0, 1, 0);
    acc(32'hFEDA_1234, 1, 0, 0, 1, 0, 32'h000A_1234);
    acc(TB + 32'h10, 1, 0, 0, 1, 0, TB + 32'h10);
    acc(TB + 32'h000F_FFFF, 1, 0, 0, 1, 0, TB + 32'h000F_FFFF);
    acc(TB + 32'h0010_0000, 1, 0, 0, 0, 0, 0);
    acc(32'hFEDB_FFFF, 0, 0, 0, 0, 0, 0);
    rd(8'h61, 8'hF9);
    wr(8'h61, 8'hC1);
    rd(8'h61, 8'hB9);
    wr(8'h60, 8'h48); // open without close
    rd(8'h60, 8'h4A);
    acc(32'h000B_FFFF, 0, 0, 0, 1, 0, 32'h000B_FFFF);
    wr(8'h60, 8'h28); // close without open
    acc(32'h000A_0000, 1, 0, 0, 0, 0, 0);
    acc(32'h000A_0000, 1, 1, 0, 1, 0, 32'h000A_0000);
    acc(32'hFEDA_0000, 1, 0, 0, 0, 0, 0);
    acc(TB, 1, 0, 0, 0, 0, 0);
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h02);
    acc(32'hFEDA_0000, 1, 0, 0, 0, 0, 0);
    acc(TB, 1, 0, 0, 0, 0, 0);
    wr(8'h60, 8'h08);
    wr(8'h60, 8'h18); // open already clear
    rd(8'h60, 8'h1A);
    chk("cfg_locked", 1, cfg_locked);
    wr(8'h60, 8'h40);
    rd(8'h60, 8'h1A);
    wr(8'h61, 8'h00);
    rd(8'h61, 8'hB9);
    @(negedge clk_sys);
    resetn = 1'b0;
    @(negedge clk_sys);
    resetn = 1'b1;
    rd(8'h60, 8'h02);
    rd(8'h61, 8'h38);
    chk("cfg_locked", 0, cfg_locked);
    wrap_up;
  end
  // watchdog against a hung sequence
  initial
  begin
    #200000;
    num_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
